// ### testbench/arc_breaker_model.sv
`timescale 1ns/100ps
module arc_breaker_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic close_in,
  input wire logic trip_in,
  input wire logic [3:0] delay_in,
  output logic closed_out,
  output logic ready_out
);
  logic [3:0] cnt_q;
  logic target_q;

  // Contacts move only after the mechanism delay; a trip wins over a close
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 4'h0;
      target_q <= 1'b0;
      closed_out <= 1'b0;
    end else if (trip_in || close_in) begin
      target_q <= close_in && !trip_in;
      cnt_q <= delay_in;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      closed_out <= target_q;
    end
  end

  // Mechanism not ready while it is still travelling
  assign ready_out = (cnt_q == 4'h0);
endmodule

// ### testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import arc_pkg::*;
  localparam int DEAD_MS = 4;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sync_clear = 1'b0;
  logic man_close = 1'b0;
  logic trip_cmd = 1'b0;
  logic [3:0] dly = 4'h1;
  logic brk_closed;
  logic brk_ready;
  arc_cfg_t cfg;
  arc_sense_t sense_v = '0;
  arc_sense_t sense_w;
  arc_status_t st;
  int seed = 81720;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;

  always #5 clk_in = ~clk_in;

  always_comb begin
    sense_w = sense_v;
    sense_w.breaker_closed = brk_closed;
    sense_w.breaker_ready = brk_ready;
  end

  arc_sequencer #(.TICK_CYCLES_P(10)) uut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sync_clear_in(sync_clear),
    .cfg_in(cfg),
    .sense_in(sense_w),
    .status_out(st)
  );

  arc_breaker_model brk (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .close_in(man_close | st.reclose_cmd),
    .trip_in(trip_cmd),
    .delay_in(dly),
    .closed_out(brk_closed),
    .ready_out(brk_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Alarm noise and breaker travel time vary every cycle
  always @(negedge clk_in) begin
    sense_v.service_alarm <= 1'($random(seed));
    dly <= 4'(($random(seed) & 7) + 1);
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] lim_shots(input logic [2:0] s);
    return (s > 3'h6) ? 3'h6 : s;
  endfunction

  task automatic test_done;
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Bounded wait, so a stuck state shows up as a mismatch, not a hang
  task automatic wait_st(input arc_state_t s, input int lim);
    int i;
    i = 0;
    while (st.state !== s && i < lim) begin
      tick(1);
      i++;
    end
    chk(st.state, s);
  endtask

  task automatic pulse_close;
    man_close = 1'b1;
    tick(1);
    man_close = 1'b0;
  endtask

  task automatic unlock;
    sense_v.lockout_reset = 1'b1;
    tick(1);
    sense_v.lockout_reset = 1'b0;
    tick(25);
    chk(st.state, ARC_LOCKOUT);
    wait_st(ARC_READY, 40);
  endtask

  // One shot; keep holds a pickup over the dead time, which must lock out
  task automatic shot(input logic [2:0] n, input logic keep);
    int c;
    sense_v.init_trip = 1'b1;
    trip_cmd = 1'b1;
    tick(1);
    trip_cmd = 1'b0;
    chk(st.state, ARC_RUNNING);
    wait_st(ARC_WAIT_OPEN, 5);
    sense_v.init_trip = 1'b0;
    wait_st(ARC_DEAD, 20);
    sense_v.init_pickup = keep;
    c = 0;
    while (st.reclose_cmd !== 1'b1 && st.state !== ARC_LOCKOUT && c < 100) begin
      tick(1);
      c++;
    end
    chk(c >= (DEAD_MS - 1) * 10 - 1 && c <= DEAD_MS * 10 + 2, 1'b1);
    if (keep) begin
      chk(st.state, ARC_LOCKOUT);
      chk(st.reclose_cmd, 1'b0);
      sense_v.init_pickup = 1'b0;
    end else begin
      chk(st.state, ARC_RECLOSING);
      chk(st.shot, n);
      tick(1);
      chk(st.reclose_cmd, 1'b0);
      wait_st(ARC_RECLAIM, 30);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cfg = '0;
    cfg.enable = 1'b1;
    cfg.ready_input_used = 1'b1;
    cfg.shots = 3'h7;
    cfg.man_hold_ms = 16'h0003;
    cfg.fault_ms = 16'h0005;
    cfg.dead_ms = 16'(DEAD_MS);
    cfg.reclose_superv_ms = 16'h0005;
    cfg.reclaim_ms = 16'h0006;
    cfg.lockout_reset_ms = 16'h0004;
    tick(12);
    rst_n_in = 1'b1;
    tick(1);
    chk(st.state, ARC_STANDBY);
    chk({st.shot, st.successful, st.failed, st.reclose_cmd}, 16'h0000);
    sense_v.init_trip = 1'b1;
    sense_v.init_pickup = 1'b1;
    for (k = 0; k < 6; k++) begin
      tick(1);
      chk(st.reclose_cmd, 1'b0);
    end
    sense_v.init_trip = 1'b0;
    sense_v.init_pickup = 1'b0;
    chk(st.state, ARC_STANDBY);
    pulse_close();
    wait_st(ARC_MAN_HOLD, 20);
    trip_cmd = 1'b1;
    tick(1);
    trip_cmd = 1'b0;
    tick(12);
    chk(st.state, ARC_MAN_HOLD);
    wait_st(ARC_STANDBY, 40);
    pulse_close();
    wait_st(ARC_MAN_HOLD, 20);
    tick(15);
    chk(st.state, ARC_MAN_HOLD);
    wait_st(ARC_READY, 30);
    sense_v.block = 1'b1;
    wait_st(ARC_BLOCKED, 5);
    sense_v.block = 1'b0;
    wait_st(ARC_READY, 5);
    tick(20);
    chk(st.state, ARC_READY);
    shot(3'h1, 1'b0);
    wait_st(ARC_READY, 80);
    chk(st.successful, 1'b1);
    for (k = 1; k <= lim_shots(cfg.shots); k++) begin
      shot(3'(k), 1'b0);
    end
    sense_v.init_trip = 1'b1;
    wait_st(ARC_LOCKOUT, 5);
    sense_v.init_trip = 1'b0;
    chk(st.failed, 1'b1);
    tick(30);
    chk(st.state, ARC_LOCKOUT);
    unlock();
    sense_v.init_pickup = 1'b1;
    wait_st(ARC_RUNNING, 5);
    wait_st(ARC_LOCKOUT, 70);
    sense_v.init_pickup = 1'b0;
    unlock();
    // Manual close in the middle of a sequence must lock out at once
    sense_v.init_pickup = 1'b1;
    wait_st(ARC_RUNNING, 5);
    sense_v.manual_close = 1'b1;
    wait_st(ARC_LOCKOUT, 3);
    sense_v.manual_close = 1'b0;
    sense_v.init_pickup = 1'b0;
    unlock();
    shot(3'h1, 1'b1);
    sync_clear = 1'b1;
    tick(1);
    sync_clear = 1'b0;
    tick(1);
    chk(st.state, ARC_STANDBY);
    chk({st.shot, st.successful, st.failed}, 16'h0000);
    test_done();
  end
endmodule

// ### verilog/arc_pkg.sv
package arc_pkg;

  // Time base: one tick per millisecond at 100 MHz
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W = 17;

  // Timer widths in milliseconds
  localparam int unsigned MS_W = 16;
  localparam int unsigned SHOT_W = 3;
  localparam logic [SHOT_W-1:0] MAX_SHOTS = 3'h6;
  localparam logic [MS_W-1:0] BRK_SUPERV_MS = 16'h00c8;

  // Reset values
  localparam logic [SHOT_W-1:0] SHOT_RST = 3'h0;
  localparam logic [MS_W-1:0] TIMER_RST = 16'h0000;

  typedef enum logic [3:0] {
    ARC_STANDBY,
    ARC_MAN_HOLD,
    ARC_READY,
    ARC_RUNNING,
    ARC_WAIT_OPEN,
    ARC_DEAD,
    ARC_RECLOSING,
    ARC_RECLAIM,
    ARC_BLOCKED,
    ARC_LOCKOUT
  } arc_state_t;

  // Programmed settings, all times in milliseconds
  typedef struct packed {
    logic enable;
    logic ready_input_used;
    logic [SHOT_W-1:0] shots;
    logic [MS_W-1:0] man_hold_ms;
    logic [MS_W-1:0] fault_ms;
    logic [MS_W-1:0] dead_ms;
    logic [MS_W-1:0] reclose_superv_ms;
    logic [MS_W-1:0] reclaim_ms;
    logic [MS_W-1:0] lockout_reset_ms;
  } arc_cfg_t;

  // Breaker and protection inputs, already synchronous to clk_in
  typedef struct packed {
    logic breaker_closed;
    logic breaker_ready;
    logic init_pickup;
    logic init_trip;
    logic general_trip;
    logic block;
    logic rate_exceeded;
    logic breaker_fail;
    logic manual_close;
    logic lockout_reset;
    logic service_alarm;
  } arc_sense_t;

  typedef struct packed {
    logic reclose_cmd;
    logic [SHOT_W-1:0] shot;
    logic successful;
    logic failed;
    arc_state_t state;
  } arc_status_t;

endpackage

// ### verilog/arc_sequencer.sv
`timescale 1ns/100ps
module arc_sequencer #(
  parameter int unsigned TICK_CYCLES_P = arc_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sync_clear_in,
  input wire arc_pkg::arc_cfg_t cfg_in,
  input wire arc_pkg::arc_sense_t sense_in,
  output arc_pkg::arc_status_t status_out
);
  import arc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    arc_state_t state;
    logic [MS_W-1:0] timer;
    logic [MS_W-1:0] fault_timer;
    logic [SHOT_W-1:0] shot;
    logic reclose;
    logic successful;
    logic failed;
    logic reset_seen;
    logic [1:0] brk_prev;
  } arc_seq_st_t;

  arc_seq_st_t s_q;
  arc_seq_st_t s_d;
  logic tick;
  logic [SHOT_W-1:0] shot_limit;
  logic timer_done;
  logic fault_done;
  logic lock_cond;
  logic brk_rise;

  // Counts down on each tick and holds at zero; timer_done reports expiry
  function automatic logic [MS_W-1:0] count_down(input logic [MS_W-1:0] t, input logic en);
    count_down = (en && t != '0) ? t - 1'b1 : t;
  endfunction

  arc_tick #(
    .CYCLES(TICK_CYCLES_P)
  ) u_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .tick_out(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Over-range settings clamp rather than wrap, so a bad setting still locks out
  assign shot_limit = (cfg_in.shots > MAX_SHOTS) ? MAX_SHOTS : cfg_in.shots;
  assign timer_done = (s_q.timer == '0);
  assign fault_done = (s_q.fault_timer == '0);
  // Service alarm deliberately absent from this term
  assign lock_cond = sense_in.rate_exceeded || sense_in.manual_close;
  assign brk_rise = sense_in.breaker_closed && !s_q.brk_prev[0];

  always_comb begin
    s_d = s_q;
    s_d.reclose = 1'b0;
    s_d.brk_prev = {s_q.brk_prev[0], sense_in.breaker_closed};
    s_d.timer = count_down(s_q.timer, tick);
    s_d.fault_timer = count_down(s_q.fault_timer, tick);
    unique case (s_q.state)
      ARC_STANDBY: begin
        if (cfg_in.enable && sense_in.block) begin
          s_d.state = ARC_BLOCKED;
        end else if (brk_rise) begin
          s_d.state = ARC_MAN_HOLD;
          s_d.timer = cfg_in.man_hold_ms;
        end
      end
      ARC_MAN_HOLD: begin
        // Trips here are ignored; only the timer decides
        if (timer_done) begin
          s_d.state = sense_in.breaker_closed ? ARC_READY : ARC_STANDBY;
        end
      end
      ARC_READY: begin
        if (!sense_in.breaker_closed) begin
          s_d.state = ARC_STANDBY;
        end else if (cfg_in.enable && sense_in.block) begin
          s_d.state = ARC_BLOCKED;
        end else if (cfg_in.enable && (sense_in.init_pickup || sense_in.init_trip)) begin
          s_d.state = ARC_RUNNING;
          s_d.fault_timer = cfg_in.fault_ms;
          s_d.shot = SHOT_RST;
          s_d.successful = 1'b0;
          s_d.failed = 1'b0;
        end
      end
      ARC_RUNNING: begin
        if (sense_in.block) begin
          s_d.state = ARC_BLOCKED;
        end else if (lock_cond || fault_done) begin
          s_d.state = ARC_LOCKOUT;
        end else if (sense_in.init_trip) begin
          s_d.state = ARC_WAIT_OPEN;
          s_d.timer = BRK_SUPERV_MS;
        end
      end
      ARC_WAIT_OPEN: begin
        if (sense_in.block) begin
          s_d.state = ARC_BLOCKED;
        end else if (!sense_in.breaker_closed) begin
          s_d.state = ARC_DEAD;
          s_d.timer = cfg_in.dead_ms;
        end else if (lock_cond || sense_in.breaker_fail || timer_done) begin
          s_d.state = ARC_LOCKOUT;
        end
      end
      ARC_DEAD: begin
        if (sense_in.block) begin
          s_d.state = ARC_BLOCKED;
        end else if (lock_cond || sense_in.breaker_closed) begin
          s_d.state = ARC_LOCKOUT;
        end else if (timer_done) begin
          if (sense_in.init_pickup || sense_in.init_trip || sense_in.general_trip) begin
            s_d.state = ARC_LOCKOUT;
          end else if (!cfg_in.ready_input_used || sense_in.breaker_ready) begin
            s_d.state = ARC_RECLOSING;
            s_d.shot = s_q.shot + 1'b1;
            s_d.reclose = 1'b1;
            s_d.timer = cfg_in.reclose_superv_ms;
          end
        end
      end
      ARC_RECLOSING: begin
        if (sense_in.block) begin
          s_d.state = ARC_BLOCKED;
        end else if (lock_cond) begin
          s_d.state = ARC_LOCKOUT;
        end else if (sense_in.breaker_closed) begin
          s_d.state = ARC_RECLAIM;
          s_d.timer = cfg_in.reclaim_ms;
        end else if (timer_done) begin
          s_d.state = ARC_LOCKOUT;
        end
      end
      ARC_RECLAIM: begin
        if (sense_in.block) begin
          s_d.state = ARC_BLOCKED;
        end else if (lock_cond) begin
          s_d.state = ARC_LOCKOUT;
        end else if (sense_in.init_pickup || sense_in.init_trip) begin
          if (s_q.shot >= shot_limit) begin
            s_d.state = ARC_LOCKOUT;
            s_d.failed = 1'b1;
          end else begin
            s_d.state = ARC_RUNNING;
            s_d.fault_timer = cfg_in.fault_ms;
          end
        end else if (timer_done) begin
          s_d.state = ARC_READY;
          s_d.successful = 1'b1;
        end
      end
      ARC_BLOCKED: begin
        if (!sense_in.block) begin
          s_d.state = sense_in.breaker_closed ? ARC_READY : ARC_STANDBY;
        end
      end
      ARC_LOCKOUT: begin
        if (!s_q.reset_seen && sense_in.lockout_reset) begin
          s_d.reset_seen = 1'b1;
          s_d.timer = cfg_in.lockout_reset_ms;
        end else if (s_q.reset_seen && timer_done) begin
          s_d.state = sense_in.breaker_closed ? ARC_READY : ARC_STANDBY;
          s_d.reset_seen = 1'b0;
        end
      end
      default: begin
        s_d.state = ARC_STANDBY;
      end
    endcase
    if (!cfg_in.enable && s_q.state != ARC_LOCKOUT) begin
      if (s_q.state != ARC_STANDBY && s_q.state != ARC_MAN_HOLD) begin
        s_d.state = sense_in.breaker_closed ? ARC_READY : ARC_STANDBY;
      end
      s_d.reclose = 1'b0;
    end
    if (sync_clear_in) begin
      s_d.state = ARC_STANDBY;
      s_d.shot = SHOT_RST;
      s_d.successful = 1'b0;
      s_d.failed = 1'b0;
      s_d.reclose = 1'b0;
      s_d.reset_seen = 1'b0;
      s_d.timer = TIMER_RST;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '{state: ARC_STANDBY, timer: TIMER_RST, fault_timer: TIMER_RST, shot: SHOT_RST,
               reclose: 1'b0, successful: 1'b0, failed: 1'b0, reset_seen: 1'b0, brk_prev: 2'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign status_out = '{reclose_cmd: s_q.reclose, shot: s_q.shot, successful: s_q.successful,
                        failed: s_q.failed, state: s_q.state};

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_standby_no_reclose: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.state == ARC_STANDBY |=> !s_q.reclose)
    else $error("reclose issued from standby");

  a_hold_entry: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $changed(s_q.state) && s_q.state == ARC_MAN_HOLD |-> $past(s_q.state) == ARC_STANDBY)
    else $error("hold entered from wrong state");

  a_hold_exit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(s_q.state) == ARC_MAN_HOLD && s_q.state == ARC_READY |-> $past(timer_done))
    else $error("hold left before timer expiry");

  a_run_from_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(s_q.state) == ARC_READY && s_q.state == ARC_RUNNING |-> s_q.shot == 3'h0 && $past(sense_in.breaker_closed))
    else $error("run entered incorrectly");

  a_block_enters: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.state == ARC_RUNNING && sense_in.block && cfg_in.enable && !sync_clear_in |=> s_q.state == ARC_BLOCKED)
    else $error("block ignored while running");

  a_lockout_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.state == ARC_LOCKOUT && !s_q.reset_seen && !sync_clear_in |=> s_q.state == ARC_LOCKOUT)
    else $error("lockout left without reset");

  a_shot_then_cmd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.reclose |-> s_q.shot == $past(s_q.shot) + 3'h1 && s_q.state == ARC_RECLOSING)
    else $error("shot not incremented with reclose");

  a_cmd_single: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.reclose |=> !s_q.reclose)
    else $error("reclose longer than one cycle");

  a_shot_limit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.shot <= MAX_SHOTS)
    else $error("shot counter above six");

endmodule

// ### verilog/arc_tick.sv
`timescale 1ns/100ps
module arc_tick #(
  parameter int unsigned CYCLES = arc_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic tick_out
);
  import arc_pkg::*;

  typedef struct packed {
    logic [TICK_CNT_W-1:0] cnt;
    logic tick;
  } arc_tick_st_t;

  arc_tick_st_t s_q;
  arc_tick_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == TICK_CNT_W'(CYCLES - 1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;

  a_tick_single: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.tick |=> !s_q.tick)
    else $error("tick lasted more than one cycle");

endmodule
